// ---- rtl/sub_skip_pkg.sv ----
// constants for the subtract / decrement-skip / set-byte execution block
// assumes a single core clock and a synchronous active-low core reset
package sub_skip_pkg;
	// ==========================================================
	// operation codes from the decoder
	typedef enum logic [2:0] {
		OP_NONE,
		OP_SUB_WITH_BORROW_TO_W,
		OP_SUB_WITH_BORROW_TO_MEM,
		OP_STEP_DOWN_SKIP_IF_ZERO,
		OP_STEP_DOWN_TO_W_SKIP_IF_ZERO,
		OP_SET_MEM
	} op_t;

	// ==========================================================
	// reset values, data constants and the half-borrow bit index
	localparam logic [7:0] W_RESET     = 8'h00;
	localparam logic [7:0] ALL_ONES    = 8'hff;
	localparam logic [7:0] ONE         = 8'h01;
	localparam logic       FLAG_RESET  = 1'h0;
	localparam logic [3:0] NIBBLE_ONES = 4'hf;
	localparam int         HALF_BIT    = 4;
endpackage

// ---- rtl/sub_skip_exec.sv ----
// execution datapath for subtract-with-borrow, decrement-and-skip and set-byte
// assumes the decoder presents one op with its memory byte per cycle, and honours o_SKIP_BUSY
// Operation
// RQ1: sub_with_borrow_to_w puts working_register minus byte minus not-carry into working_register.
// RQ2: sub_with_borrow_to_mem computes the same difference and writes it to the addressed byte.
// RQ3: after either subtract the carry is 0 on a negative result and 1 on positive or zero.
// RQ4: both subtracts update signed_wrap_flag, zero, half_borrow_flag and carry.
// RQ5: step_down_skip_if_zero writes byte minus one back and skips when it is zero.
// RQ6: step_down_to_w_skip_if_zero puts byte minus one in working_register, memory untouched, skip on zero.
// RQ7: a skip inserts one dummy cycle so the skipping instruction takes two machine cycles.
// RQ8: decrement-skip instructions leave every flag unchanged.
// RQ9: set-memory writes all ones into the addressed byte.
// RQ10: zero flag on zero result, half borrow from bit 3, signed wrap on two's-complement overflow.
// RQ11: non-skipping instructions take one cycle and never insert a dummy cycle.
`timescale 1ns/10ps
`default_nettype none
module sub_skip_exec (
	input  wire logic                I_MCLK,
	input  wire logic                I_RESET_N,
	input  wire sub_skip_pkg::op_t   I_OP,
	input  wire logic [7:0]          I_MEM_RDATA,
	output logic                     O_MEM_WE,
	output logic      [7:0]          O_MEM_WDATA,
	output logic      [7:0]          O_WORKING_REGISTER,
	output logic                     O_CARRY,
	output logic                     O_ZERO,
	output logic                     O_SIGNED_WRAP_FLAG,
	output logic                     O_HALF_BORROW_FLAG,
	output logic                     O_SKIP_BUSY
);
	// ==========================================================
	// arithmetic
	logic [8:0] diff;
	logic [4:0] low_diff;
	logic [7:0] dec;
	logic       borrow_in;
	logic       is_sub;
	logic       is_dec;
	logic       next_skip;

	// borrow in is the inverted carry
	assign borrow_in = ~O_CARRY;
	assign is_sub    = (I_OP == sub_skip_pkg::OP_SUB_WITH_BORROW_TO_W) ||
		(I_OP == sub_skip_pkg::OP_SUB_WITH_BORROW_TO_MEM);
	assign is_dec    = (I_OP == sub_skip_pkg::OP_STEP_DOWN_SKIP_IF_ZERO) ||
		(I_OP == sub_skip_pkg::OP_STEP_DOWN_TO_W_SKIP_IF_ZERO);
	// RQ1 difference core
	assign diff      = {1'h0, O_WORKING_REGISTER} - {1'h0, I_MEM_RDATA} - {8'h00, borrow_in};
	assign low_diff  = {1'h0, O_WORKING_REGISTER[3:0]} - {1'h0, I_MEM_RDATA[3:0]} - {4'h0, borrow_in};
	assign dec       = I_MEM_RDATA - sub_skip_pkg::ONE;
	// RQ5 zero test on decrement
	assign next_skip = is_dec && (dec == 8'h00) && !O_SKIP_BUSY;

	// ==========================================================
	// working register
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			O_WORKING_REGISTER <= sub_skip_pkg::W_RESET;
		end else if (!O_SKIP_BUSY) begin
			// RQ1 result to w
			if (I_OP == sub_skip_pkg::OP_SUB_WITH_BORROW_TO_W) begin
				O_WORKING_REGISTER <= diff[7:0];
			// RQ6 decrement to w
			end else if (I_OP == sub_skip_pkg::OP_STEP_DOWN_TO_W_SKIP_IF_ZERO) begin
				O_WORKING_REGISTER <= dec;
			end
		end
	end

	// ==========================================================
	// memory write port, registered so the outputs come from flops
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			O_MEM_WE    <= sub_skip_pkg::FLAG_RESET;
			O_MEM_WDATA <= sub_skip_pkg::W_RESET;
		end else begin
			O_MEM_WE    <= 1'h0;
			O_MEM_WDATA <= O_MEM_WDATA;
			if (!O_SKIP_BUSY) begin
				unique case (I_OP)
					// RQ2 result to memory
					sub_skip_pkg::OP_SUB_WITH_BORROW_TO_MEM: begin
						O_MEM_WE    <= 1'h1;
						O_MEM_WDATA <= diff[7:0];
					end
					// RQ5 write back decrement
					sub_skip_pkg::OP_STEP_DOWN_SKIP_IF_ZERO: begin
						O_MEM_WE    <= 1'h1;
						O_MEM_WDATA <= dec;
					end
					// RQ9 all ones
					sub_skip_pkg::OP_SET_MEM: begin
						O_MEM_WE    <= 1'h1;
						O_MEM_WDATA <= sub_skip_pkg::ALL_ONES;
					end
					default: begin
						O_MEM_WE <= 1'h0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// status flags; decrements never touch them
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			O_CARRY            <= sub_skip_pkg::FLAG_RESET;
			O_ZERO             <= sub_skip_pkg::FLAG_RESET;
			O_SIGNED_WRAP_FLAG <= sub_skip_pkg::FLAG_RESET;
			O_HALF_BORROW_FLAG <= sub_skip_pkg::FLAG_RESET;
		// RQ4 update all four
		end else if (is_sub && !O_SKIP_BUSY) begin
			// RQ3 carry is not borrow
			O_CARRY            <= ~diff[8];
			// RQ10 zero half wrap
			O_ZERO             <= (diff[7:0] == 8'h00);
			O_HALF_BORROW_FLAG <= ~low_diff[sub_skip_pkg::HALF_BIT];
			O_SIGNED_WRAP_FLAG <= (O_WORKING_REGISTER[7] != I_MEM_RDATA[7]) && (diff[7] != O_WORKING_REGISTER[7]);
		end else begin
			// RQ8 flags held
			O_CARRY            <= O_CARRY;
			O_ZERO             <= O_ZERO;
			O_SIGNED_WRAP_FLAG <= O_SIGNED_WRAP_FLAG;
			O_HALF_BORROW_FLAG <= O_HALF_BORROW_FLAG;
		end
	end

	// ==========================================================
	// skip: one dummy cycle while the next instruction is fetched
	// RQ7 dummy cycle insert
	// RQ11 no dummy otherwise
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			O_SKIP_BUSY <= sub_skip_pkg::FLAG_RESET;
		end else begin
			O_SKIP_BUSY <= next_skip;
		end
	end

	// ==========================================================
	// checks: skip timing
	sequence dec_zero_s;
		!O_SKIP_BUSY && is_dec && (I_MEM_RDATA == sub_skip_pkg::ONE);
	endsequence

	// the dummy slot lasts one cycle, then the next op is accepted again
	sequence skip_slot_s;
		O_SKIP_BUSY ##1 !O_SKIP_BUSY;
	endsequence

	// RQ7 one dummy cycle
	a_skip_one_cycle: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ7
		dec_zero_s |=> skip_slot_s) else $error("skip dummy cycle wrong");
	// RQ11 no stray dummy
	a_no_skip_nonzero: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ11
		(!O_SKIP_BUSY && !(is_dec && I_MEM_RDATA == sub_skip_pkg::ONE)) |=> !O_SKIP_BUSY)
		else $error("unexpected dummy cycle");
	// RQ7 slot op ignored
	a_skip_refused: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ7
		O_SKIP_BUSY |=> !O_MEM_WE && $stable(O_WORKING_REGISTER)) else $error("op in dummy slot acted");
	// RQ11 idle does nothing
	a_idle_quiet: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ11
		(!O_SKIP_BUSY && I_OP == sub_skip_pkg::OP_NONE) |=> !O_MEM_WE && $stable(O_WORKING_REGISTER)
		&& $stable(O_CARRY) && $stable(O_ZERO)) else $error("idle cycle changed state");

	// ==========================================================
	// checks: subtract results and flags
	// RQ1 result to w
	a_sub_to_w: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ1
		(!O_SKIP_BUSY && I_OP == sub_skip_pkg::OP_SUB_WITH_BORROW_TO_W) |=>
		O_WORKING_REGISTER == $past(O_WORKING_REGISTER) - $past(I_MEM_RDATA) - {7'h00, ~$past(O_CARRY)})
		else $error("subtract to w wrong");
	// RQ2 w kept, write issued
	a_sub_to_mem: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ2
		(!O_SKIP_BUSY && I_OP == sub_skip_pkg::OP_SUB_WITH_BORROW_TO_MEM) |=>
		O_MEM_WE && O_WORKING_REGISTER == $past(O_WORKING_REGISTER)) else $error("subtract to mem wrong");
	// RQ2 difference to memory
	a_sub_mem_data: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ2
		(!O_SKIP_BUSY && I_OP == sub_skip_pkg::OP_SUB_WITH_BORROW_TO_MEM) |=>
		O_MEM_WDATA == $past(O_WORKING_REGISTER) - $past(I_MEM_RDATA) - {7'h00, ~$past(O_CARRY)})
		else $error("subtract data to mem wrong");
	// RQ3 negative clears carry
	a_carry_sign: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ3
		(!O_SKIP_BUSY && is_sub && O_CARRY && O_WORKING_REGISTER < I_MEM_RDATA) |=> !O_CARRY)
		else $error("carry not cleared on negative");
	// RQ3 positive sets carry
	a_carry_set: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ3
		(!O_SKIP_BUSY && is_sub && O_WORKING_REGISTER > I_MEM_RDATA) |=> O_CARRY)
		else $error("carry not set on positive");
	// RQ10 zero result
	a_zero_flag: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ10
		(!O_SKIP_BUSY && is_sub && O_CARRY && O_WORKING_REGISTER == I_MEM_RDATA) |=> O_ZERO && O_CARRY)
		else $error("zero flag wrong");
	// RQ10 nonzero result
	a_zero_clear: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ10
		(!O_SKIP_BUSY && is_sub && O_CARRY && O_WORKING_REGISTER != I_MEM_RDATA) |=> !O_ZERO)
		else $error("zero flag set on nonzero");
	// RQ10 no nibble borrow
	a_half_borrow_set: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ10
		(!O_SKIP_BUSY && is_sub && O_CARRY && O_WORKING_REGISTER[3:0] >= I_MEM_RDATA[3:0]) |=>
		O_HALF_BORROW_FLAG) else $error("half borrow not set");
	// RQ10 nibble borrow
	a_half_borrow_clr: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ10
		(!O_SKIP_BUSY && is_sub && O_WORKING_REGISTER[3:0] < I_MEM_RDATA[3:0]) |=>
		!O_HALF_BORROW_FLAG) else $error("half borrow not cleared");
	// RQ4 signed wrap set
	a_wrap_flag: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ4
		(!O_SKIP_BUSY && is_sub && O_CARRY && O_WORKING_REGISTER == 8'h80 && I_MEM_RDATA == 8'h01) |=>
		O_SIGNED_WRAP_FLAG && O_WORKING_REGISTER == 8'h7f) else $error("signed wrap wrong");
	// RQ10 like signs never wrap
	a_wrap_clear: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ10
		(!O_SKIP_BUSY && is_sub && O_WORKING_REGISTER[7] == I_MEM_RDATA[7]) |=> !O_SIGNED_WRAP_FLAG)
		else $error("signed wrap on like signs");

	// ==========================================================
	// checks: decrement and set
	// RQ8 flags untouched
	a_dec_flags_kept: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ8
		(is_dec || O_SKIP_BUSY) |=> $stable(O_CARRY) && $stable(O_ZERO) && $stable(O_SIGNED_WRAP_FLAG)
		&& $stable(O_HALF_BORROW_FLAG)) else $error("decrement changed flags");
	// RQ6 decrement to w
	a_dec_to_w: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ6
		(!O_SKIP_BUSY && I_OP == sub_skip_pkg::OP_STEP_DOWN_TO_W_SKIP_IF_ZERO) |=>
		!O_MEM_WE && O_WORKING_REGISTER == $past(I_MEM_RDATA) - 8'h01) else $error("decrement to w wrong");
	// RQ5 decrement written back
	a_dec_mem: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ5
		(!O_SKIP_BUSY && I_OP == sub_skip_pkg::OP_STEP_DOWN_SKIP_IF_ZERO) |=>
		O_MEM_WE && O_MEM_WDATA == $past(I_MEM_RDATA) - 8'h01) else $error("decrement to mem wrong");
	// RQ9 all ones written
	a_set_all: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RQ9
		(!O_SKIP_BUSY && I_OP == sub_skip_pkg::OP_SET_MEM) |=> O_MEM_WE && O_MEM_WDATA == sub_skip_pkg::ALL_ONES)
		else $error("set byte wrong");
endmodule
`default_nettype wire

// ---- verif/mem_model.sv ----
// partner model: the addressed data memory byte seen by the execution block
// assumes the bench preloads the byte between ops and the block writes on its pulse
`timescale 1ns/10ps
`default_nettype none
module mem_model (
	input  wire logic       i_clk,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_load,
	input  wire logic [7:0] i_load_val,
	output logic      [7:0] o_rdata
);
	// ==========================================================
	// storage: a block write wins over a preload, as a real port would
	always_ff @(posedge i_clk) begin
		if (i_we)
			o_rdata <= i_wdata;
		else if (i_load)
			o_rdata <= i_load_val;
	end
endmodule
`default_nettype wire

// ---- verif/subtract_decrement_skip_exec_tb.sv ----
// self-checking bench for the subtract / decrement-skip / set-byte block
// assumes sub_skip_pkg and mem_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module subtract_decrement_skip_exec_tb;
	logic              i_mclk     = 1'b0;
	logic              i_reset_n  = 1'b0;
	sub_skip_pkg::op_t i_op       = sub_skip_pkg::OP_NONE;
	logic              load       = 1'b0;
	logic [7:0]        load_val   = 8'h00;
	logic [7:0]        rdata, wdata, w;
	logic              we, c, z, v, h, busy;
	int                n_mismatch = 0;
	int                cmp_count  = 0;
	// ==========================================================
	// clock and instances
	always #25 i_mclk = ~i_mclk;
	sub_skip_exec sub_skip_exec_inst (.I_MCLK(i_mclk), .I_RESET_N(i_reset_n), .I_OP(i_op),
		.I_MEM_RDATA(rdata), .O_MEM_WE(we), .O_MEM_WDATA(wdata), .O_WORKING_REGISTER(w),
		.O_CARRY(c), .O_ZERO(z), .O_SIGNED_WRAP_FLAG(v), .O_HALF_BORROW_FLAG(h), .O_SKIP_BUSY(busy));
	mem_model mem_model_inst (.i_clk(i_mclk), .i_we(we), .i_wdata(wdata), .i_load(load),
		.i_load_val(load_val), .o_rdata(rdata));
	// ==========================================================
	// shared compare and verdict
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// preload byte, issue op, judge answer; after a skip a stray op sits in the dummy slot
	task automatic run_op(input sub_skip_pkg::op_t op, input logic [7:0] m, input logic [7:0] ew,
		input logic ewe, input logic [7:0] ewd, input logic [3:0] ef, input logic esk);
		@(negedge i_mclk);
		load = 1'b1;
		load_val = m;
		@(negedge i_mclk);
		load = 1'b0;
		i_op = op;
		@(negedge i_mclk);
		if (esk)
			i_op = sub_skip_pkg::OP_SET_MEM;
		else
			i_op = sub_skip_pkg::OP_NONE;
		chk("working_register", ew, w);
		chk("mem_we", {7'h00, ewe}, {7'h00, we});
		if (ewe) chk("mem_wdata", ewd, wdata);
		chk("flags", {4'h0, ef}, {4'h0, c, z, v, h});
		chk("skip_busy", {7'h00, esk}, {7'h00, busy});
		@(negedge i_mclk);
		i_op = sub_skip_pkg::OP_NONE;
		chk("slot_we", 8'h00, {7'h00, we});
		chk("slot_busy", 8'h00, {7'h00, busy});
		chk("slot_w", ew, w);
	endtask
	// ==========================================================
	// scenarios; flags packed as carry, zero, signed wrap, half borrow
	task automatic t_subtract();
		run_op(sub_skip_pkg::OP_SUB_WITH_BORROW_TO_W, 8'h00, 8'hff, 1'h0, 8'h00, 4'h0, 1'h0);
		run_op(sub_skip_pkg::OP_SUB_WITH_BORROW_TO_W, 8'h7f, 8'h7f, 1'h0, 8'h00, 4'ha, 1'h0);
		run_op(sub_skip_pkg::OP_SUB_WITH_BORROW_TO_MEM, 8'h7e, 8'h7f, 1'h1, 8'h01, 4'h9, 1'h0);
		run_op(sub_skip_pkg::OP_SUB_WITH_BORROW_TO_W, 8'h7f, 8'h00, 1'h0, 8'h00, 4'hd, 1'h0);
		$display("test subtract done");
	endtask
	task automatic t_decrement();
		run_op(sub_skip_pkg::OP_STEP_DOWN_SKIP_IF_ZERO, 8'h01, 8'h00, 1'h1, 8'h00, 4'hd, 1'h1);
		run_op(sub_skip_pkg::OP_STEP_DOWN_TO_W_SKIP_IF_ZERO, 8'h05, 8'h04, 1'h0, 8'h00, 4'hd, 1'h0);
		run_op(sub_skip_pkg::OP_STEP_DOWN_TO_W_SKIP_IF_ZERO, 8'h01, 8'h00, 1'h0, 8'h00, 4'hd, 1'h1);
		run_op(sub_skip_pkg::OP_STEP_DOWN_SKIP_IF_ZERO, 8'h00, 8'h00, 1'h1, 8'hff, 4'hd, 1'h0);
		$display("test decrement done");
	endtask
	task automatic t_set();
		run_op(sub_skip_pkg::OP_SET_MEM, 8'h5a, 8'h00, 1'h1, 8'hff, 4'hd, 1'h0);
		$display("test set done");
	endtask
	// signed wrap from 80h, then a negative result with carry set beforehand
	task automatic t_borrow();
		run_op(sub_skip_pkg::OP_STEP_DOWN_TO_W_SKIP_IF_ZERO, 8'h81, 8'h80, 1'h0, 8'h00, 4'hd, 1'h0);
		run_op(sub_skip_pkg::OP_SUB_WITH_BORROW_TO_W, 8'h01, 8'h7f, 1'h0, 8'h00, 4'ha, 1'h0);
		run_op(sub_skip_pkg::OP_SUB_WITH_BORROW_TO_MEM, 8'h80, 8'h7f, 1'h1, 8'hff, 4'h3, 1'h0);
		$display("test borrow done");
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (8) @(negedge i_mclk);
		i_reset_n = 1'b1;
		chk("reset_w", 8'h00, w);
		chk("reset_flags", 8'h00, {2'b00, c, z, v, h, we, busy});
		t_subtract();
		t_decrement();
		t_set();
		t_borrow();
		print_verdict();
	end
	initial begin
		#(400 * 50);
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
